// ===== pkg/charger_status_regs.svh
`ifndef CHARGER_STATUS_REGS_SVH
`define CHARGER_STATUS_REGS_SVH

// register byte offsets on the wishbone slave
`define CSR_CTRL_OFS 8'h00
`define CSR_FAULT_OFS 8'h04
`define CSR_CHANGE_OFS 8'h08
`define CSR_LIVE_OFS 8'h0c

// control register fields
`define CTRL_OVP_SEL_LSB 0
`define CTRL_BOOST_EN_BIT 2
`define CTRL_VDPM_MASK_BIT 3
`define CTRL_IDPM_MASK_BIT 4
`define CTRL_OVP_SEL_RST 2'h3
`define CTRL_BOOST_EN_RST 1'h0
`define CTRL_MASK_RST 1'h0

// fault register fields
`define FAULT_BOOST_BIT 6
`define FAULT_CODE_LSB 4
`define FAULT_BAT_BIT 3

// status change fields, live loop bits in [1:0]
`define CHG_INPUT_BIT 6
`define CHG_CHARGE_BIT 5
`define CHG_SOURCE_BIT 4
`define CHG_VDPM_BIT 1
`define CHG_IDPM_BIT 0

// charge fault codes
`define CODE_NONE 2'h0
`define CODE_INPUT_OVP 2'h1
`define CODE_THERMAL 2'h2
`define CODE_TIMER 2'h3

// timing
`define CLK_KHZ 40000
`define INT_PULSE_US 256
`define BLINK_HZ 1
`define OC_LATCH_US 100

`endif

// ===== pkg/charger_status_pkg.sv
package charger_status_pkg;

	// accessory supply switch sequencing
	typedef enum logic [1:0]
	{
		APO_IDLE,
		APO_ADAPTER,
		APO_BOOST_WAIT,
		APO_BOOST
	} apo_state_t;

	typedef logic [1:0] fault_code_t;

endpackage

// ===== rtl/charger_status_fault_reporting.sv
`timescale 1ns/100ps
`include "charger_status_regs.svh"
// Overview of operation
// - input good needs all five input conditions
// - stat pin blinks 1 Hz during suspend
// - interrupt is one 256 us low pulse
// - input, source, charge, fault, top-off events interrupt
// - unmasked input regulation loop events interrupt
// - fault and change bits latch until read
// - no new pulse while latched bits pending, except unmasked loop events
// - adapter inserted: accessory ok when input valid
// - switch overcurrent or over 5.8 V drops ok
// - adapter removed: ok low before boost starts
// - boost: ok only within poor-to-overvoltage range
// - every boost exit cause drops accessory ok
// - selectable input overvoltage threshold, stops switching
// - input overvoltage sets code 01 and interrupts
// - safety timer expiry sets code 11, interrupts
// - system overvoltage stops switching, enables sink
// - boost overvoltage exits boost and flags fault
// - boost overcurrent latches off, flags fault
// - thermal regulation reduces current, halves timer
// - thermal shutdown at 150, recover at 130
// - boost enable cleared hot during boost, re-set below 145
// - battery overvoltage stops switching, flags fault
module charger_status_fault_reporting
	import charger_status_pkg::*;
#(
	parameter int INT_PULSE_CYCLES = (`INT_PULSE_US * `CLK_KHZ + 999) / 1000,
	parameter int BLINK_HALF_CYCLES = `CLK_KHZ * 1000 / (2 * `BLINK_HZ)
)
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic vbus_above_uvlo_i,
	input wire logic vbus_above_bat_i,
	input wire logic [3:0] vac_above_ovp_i,
	input wire logic poor_source_ok_i,
	input wire logic source_detect_done_i,
	input wire logic source_identified_i,
	input wire logic charging_i,
	input wire logic charge_done_i,
	input wire logic topoff_running_i,
	input wire logic safety_timer_expired_i,
	input wire logic thermistor_fault_i,
	input wire logic sys_over_i,
	input wire logic accessory_supply_node_above_poor_i,
	input wire logic accessory_supply_node_above_bst_ovp_i,
	input wire logic blocking_switch_oc_i,
	input wire logic battery_depleted_i,
	input wire logic battery_switch_oc_i,
	input wire logic input_voltage_limit_loop_i,
	input wire logic input_current_limit_loop_i,
	input wire logic tj_above_110_i,
	input wire logic tj_above_150_i,
	input wire logic tj_below_130_i,
	input wire logic tj_below_145_i,
	input wire logic vbat_over_i,
	output logic stat_o,
	output logic stat_oe_o,
	output logic int_n_o,
	output logic accessory_power_ok_o,
	output logic switching_stop_o,
	output logic sys_discharge_en_o,
	output logic converter_off_o,
	output logic battery_switch_off_o,
	output logic boost_active_o,
	output logic charge_current_reduce_o,
	output logic termination_disable_o,
	output logic timer_half_rate_o
);

	localparam int SYNC_W = 27;
	localparam int PW = $clog2(INT_PULSE_CYCLES + 1);
	localparam int BW = $clog2(BLINK_HALF_CYCLES + 1);

	////////////////////////////////////////////////////////////////////////////
	// comparator synchronisers

	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic uvlo_ok, above_bat, poor_ok, det_done, src_id, chg, chg_done, topoff, tmr_exp, ntc_flt;
	logic sys_ovp, accessory_supply_node_poor, accessory_supply_node_ovp, blk_oc, bat_dep, bsw_oc, vdpm, idpm;
	logic t110, t150, t130, t145, bat_ovp;
	logic [3:0] vac_ovp;

	// comparators are asynchronous to the clock, so two flops each
	always_ff @(posedge ref_clk_i)
	begin
		sync1_q <= {vbus_above_uvlo_i, vbus_above_bat_i, vac_above_ovp_i, poor_source_ok_i,
			source_detect_done_i, source_identified_i, charging_i, charge_done_i, topoff_running_i,
			safety_timer_expired_i, thermistor_fault_i, sys_over_i, accessory_supply_node_above_poor_i,
			accessory_supply_node_above_bst_ovp_i, blocking_switch_oc_i, battery_depleted_i, battery_switch_oc_i,
			input_voltage_limit_loop_i, input_current_limit_loop_i, tj_above_110_i,
			tj_above_150_i, tj_below_130_i, tj_below_145_i, vbat_over_i};
		sync2_q <= sync1_q;
	end

	assign {uvlo_ok, above_bat, vac_ovp, poor_ok, det_done, src_id, chg, chg_done, topoff, tmr_exp,
		ntc_flt, sys_ovp, accessory_supply_node_poor, accessory_supply_node_ovp, blk_oc, bat_dep, bsw_oc, vdpm, idpm, t110, t150,
		t130, t145, bat_ovp} = sync2_q;

	////////////////////////////////////////////////////////////////////////////
	// wishbone slave and control register

	logic [1:0] ovp_sel_q;
	logic boost_en_q;
	logic vdpm_mask_q;
	logic idpm_mask_q;
	logic ack_q;
	logic [31:0] rdat_q;
	logic req, wr_ctrl, rd_fault, rd_change;
	logic [3:0] fault_hist_q;
	logic [2:0] change_hist_q;
	logic input_good, input_ovp, boost_run, shutdown_q, boost_latch_q, blink_q, suspend;
	apo_state_t state_q;

	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `CSR_CTRL_OFS);
	// read-to-clear acts on the edge where the master takes the data
	assign rd_fault = ack_q && wb_cyc_i && wb_stb_i && !wb_we_i && (wb_adr_i == `CSR_FAULT_OFS);
	assign rd_change = ack_q && wb_cyc_i && wb_stb_i && !wb_we_i && (wb_adr_i == `CSR_CHANGE_OFS);
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// one wait state; unmapped reads return zero, unmapped writes are dropped
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end
		else
		begin
			ack_q <= req;
			if (req && !wb_we_i)
			begin
				case (wb_adr_i)
					`CSR_CTRL_OFS: rdat_q <= {27'h0, idpm_mask_q, vdpm_mask_q, boost_en_q, ovp_sel_q};
					`CSR_FAULT_OFS: rdat_q <= {25'h0, fault_hist_q, 3'h0};
					`CSR_CHANGE_OFS: rdat_q <= {25'h0, change_hist_q, 2'h0, vdpm, idpm};
					`CSR_LIVE_OFS: rdat_q <= {24'h0, t110, shutdown_q, boost_latch_q, blink_q,
						accessory_power_ok_o, boost_active_o, input_ovp, input_good};
					default: rdat_q <= 32'h0;
				endcase
			end
		end
	end

	// threshold select and loop masks
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			ovp_sel_q <= `CTRL_OVP_SEL_RST;
			vdpm_mask_q <= `CTRL_MASK_RST;
			idpm_mask_q <= `CTRL_MASK_RST;
		end
		else if (wr_ctrl)
		begin
			ovp_sel_q <= wb_dat_i[`CTRL_OVP_SEL_LSB +: 2];
			vdpm_mask_q <= wb_dat_i[`CTRL_VDPM_MASK_BIT];
			idpm_mask_q <= wb_dat_i[`CTRL_IDPM_MASK_BIT];
		end
	end

	// hardware clear beats a host write so a hot or overvoltage boost cannot be re-armed
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			boost_en_q <= `CTRL_BOOST_EN_RST;
		else if (state_q == APO_BOOST && (accessory_supply_node_ovp || t150))
			boost_en_q <= 1'b0;
		else if (wr_ctrl)
			boost_en_q <= wb_dat_i[`CTRL_BOOST_EN_BIT] && t145;
	end

	////////////////////////////////////////////////////////////////////////////
	// input qualification and protections

	assign input_ovp = vac_ovp[ovp_sel_q];
	assign input_good = uvlo_ok && above_bat && !input_ovp && poor_ok && det_done;
	assign boost_run = boost_en_q && !uvlo_ok && !boost_latch_q && !input_ovp && !ntc_flt
		&& !bat_dep && !t150;

	// thermal shutdown with hysteresis down to 130
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			shutdown_q <= 1'b0;
		else if (t150)
			shutdown_q <= 1'b1;
		else if (t130)
			shutdown_q <= 1'b0;
	end

	// boost overcurrent latch; synchroniser delay keeps it far inside 100 us
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			boost_latch_q <= 1'b0;
		else if (state_q == APO_BOOST && bsw_oc)
			boost_latch_q <= 1'b1;
		else if (wr_ctrl)
			boost_latch_q <= 1'b0;
	end

	// power stage controls; regulator stays on and no high impedance during overvoltage
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			switching_stop_o <= 1'b0;
			sys_discharge_en_o <= 1'b0;
			converter_off_o <= 1'b0;
			battery_switch_off_o <= 1'b0;
			charge_current_reduce_o <= 1'b0;
			termination_disable_o <= 1'b0;
			timer_half_rate_o <= 1'b0;
		end
		else
		begin
			switching_stop_o <= input_ovp || sys_ovp || bat_ovp || (state_q == APO_BOOST && accessory_supply_node_ovp);
			sys_discharge_en_o <= sys_ovp;
			converter_off_o <= shutdown_q || t150;
			battery_switch_off_o <= shutdown_q || t150;
			charge_current_reduce_o <= t110;
			termination_disable_o <= t110;
			timer_half_rate_o <= t110;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// accessory supply switch

	apo_state_t state_d;

	// the wait state guarantees one low cycle between adapter and boost
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			APO_IDLE:
				if (uvlo_ok)
					state_d = APO_ADAPTER;
				else if (boost_run)
					state_d = APO_BOOST_WAIT;
			APO_ADAPTER:
				if (!uvlo_ok)
					state_d = boost_run ? APO_BOOST_WAIT : APO_IDLE;
			APO_BOOST_WAIT:
				state_d = boost_run ? APO_BOOST : APO_IDLE;
			APO_BOOST:
				if (!boost_run || (accessory_supply_node_ovp))
					state_d = APO_IDLE;
			default:
				state_d = APO_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			state_q <= APO_IDLE;
			accessory_power_ok_o <= 1'b0;
			boost_active_o <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			boost_active_o <= (state_d == APO_BOOST);
			case (state_d)
				APO_ADAPTER: accessory_power_ok_o <= above_bat && !input_ovp && poor_ok && !blk_oc && !accessory_supply_node_ovp;
				APO_BOOST: accessory_power_ok_o <= accessory_supply_node_poor && !accessory_supply_node_ovp;
				default: accessory_power_ok_o <= 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// stat pin

	logic [BW-1:0] blink_cnt_q;

	// free-running half-period divider for the 1 Hz blink
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			blink_cnt_q <= '0;
			blink_q <= 1'b0;
		end
		else if (blink_cnt_q == BW'(BLINK_HALF_CYCLES - 1))
		begin
			blink_cnt_q <= '0;
			blink_q <= !blink_q;
		end
		else
			blink_cnt_q <= blink_cnt_q + 1'b1;
	end

	assign suspend = input_ovp || ntc_flt || tmr_exp || sys_ovp;
	assign stat_o = 1'b0; // open drain only ever pulls low

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			stat_oe_o <= 1'b0;
		else if (suspend)
			stat_oe_o <= blink_q;
		else
			stat_oe_o <= chg && !chg_done && state_q != APO_BOOST;
	end

	////////////////////////////////////////////////////////////////////////////
	// latched fault and change registers

	logic [3:0] fault_now, fault_prev_q;
	logic good_q, srcid_q, done_q, topoff_q, vdpm_q, idpm_q;
	logic [2:0] change_evt;
	logic fault_evt, pending, boost_flt, vdpm_evt, fire;
	fault_code_t code_now;

	// lowest code wins when several causes overlap
	assign code_now = input_ovp ? `CODE_INPUT_OVP : ((shutdown_q || t150) ? `CODE_THERMAL :
		(tmr_exp ? `CODE_TIMER : `CODE_NONE));
	assign boost_flt = (state_q == APO_BOOST && (accessory_supply_node_ovp || bsw_oc)) || boost_latch_q;
	assign fault_now = {boost_flt, code_now, bat_ovp};
	assign fault_evt = |(fault_now & ~fault_prev_q);
	assign change_evt = {good_q != input_good, (chg_done && !done_q) || (topoff != topoff_q),
		src_id && !srcid_q};
	assign vdpm_evt = (vdpm && !vdpm_q && !vdpm_mask_q) || (idpm && !idpm_q && !idpm_mask_q);
	assign pending = (|fault_hist_q) || (|change_hist_q);
	assign fire = ((fault_evt || (|change_evt)) && !pending) || vdpm_evt;

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			fault_prev_q <= 4'h0;
			{good_q, srcid_q, done_q, topoff_q, vdpm_q, idpm_q} <= 6'h0;
		end
		else
		begin
			fault_prev_q <= fault_now;
			{good_q, srcid_q, done_q, topoff_q, vdpm_q, idpm_q} <= {input_good, src_id, chg_done, topoff, vdpm, idpm};
		end
	end

	// a read reloads with present conditions, so an event on the clearing edge is not lost
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			fault_hist_q <= 4'h0;
			change_hist_q <= 3'h0;
		end
		else
		begin
			if (rd_fault)
				fault_hist_q <= fault_now;
			else
			begin
				fault_hist_q[3] <= fault_hist_q[3] || fault_now[3];
				fault_hist_q[0] <= fault_hist_q[0] || fault_now[0];
				if (fault_hist_q[2:1] == `CODE_NONE)
					fault_hist_q[2:1] <= fault_now[2:1];
			end
			if (rd_change)
				change_hist_q <= change_evt;
			else
				change_hist_q <= change_hist_q | change_evt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt pulse

	logic [PW-1:0] int_cnt_q;

	// a trigger during a running pulse is absorbed; the latched bits still tell the host
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			int_cnt_q <= '0;
			int_n_o <= 1'b1;
		end
		else if (int_cnt_q != '0)
		begin
			int_cnt_q <= int_cnt_q - 1'b1;
			int_n_o <= (int_cnt_q == PW'(1));
		end
		else if (fire)
		begin
			int_cnt_q <= PW'(INT_PULSE_CYCLES);
			int_n_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	logic [PW:0] low_len_q;

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || int_n_o)
			low_len_q <= '0;
		else
			low_len_q <= low_len_q + 1'b1;
	end

	a_int_pulse_width: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(int_n_o) |-> low_len_q == (PW + 1)'(INT_PULSE_CYCLES))
		else $error("interrupt pulse width wrong");
	a_input_good_cond: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		input_good |-> (uvlo_ok && above_bat && poor_ok && det_done && !vac_ovp[ovp_sel_q]))
		else $error("input good without all conditions");
	a_stat_blinks: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		suspend |=> stat_oe_o == $past(blink_q))
		else $error("stat pin not blinking in suspend");
	a_stat_charging: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!suspend && chg && !chg_done && state_q != APO_BOOST) |=> stat_oe_o)
		else $error("stat pin not low while charging");
	a_pending_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pending && int_n_o && !vdpm_evt) |=> int_n_o)
		else $error("interrupt while bits pending");
	a_masked_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(int_n_o && vdpm_mask_q && idpm_mask_q && !fault_evt && !(|change_evt)) |=> int_n_o)
		else $error("masked loop event interrupted");
	a_boost_gap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(state_q == APO_ADAPTER && !uvlo_ok) |=> !accessory_power_ok_o ##1 !accessory_power_ok_o)
		else $error("accessory ok not low before boost");
	a_accessory_supply_node_over_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		accessory_supply_node_ovp |=> !accessory_power_ok_o)
		else $error("accessory ok above overvoltage");
	a_boost_exit_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(state_q == APO_BOOST && !boost_run) |=> !accessory_power_ok_o && !boost_active_o)
		else $error("boost exit kept accessory ok");
	a_ovp_code: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(input_ovp && fault_hist_q[2:1] == `CODE_NONE && !rd_fault) |=> fault_hist_q[2:1] == `CODE_INPUT_OVP)
		else $error("overvoltage code not latched");
	a_system_overvoltage_react: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		sys_ovp |=> switching_stop_o && sys_discharge_en_o)
		else $error("system overvoltage not handled");
	a_boost_en_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(state_q == APO_BOOST && accessory_supply_node_ovp) |=> !boost_en_q && fault_hist_q[3])
		else $error("boost overvoltage not handled");
	a_oc_latch_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(state_q == APO_BOOST && bsw_oc) |-> ##[1:3] !boost_active_o)
		else $error("boost overcurrent not latched off");
	a_thermal_reg: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		t110 |=> charge_current_reduce_o && timer_half_rate_o && termination_disable_o)
		else $error("thermal regulation not applied");
	a_shutdown_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(shutdown_q && !t130) |=> converter_off_o && battery_switch_off_o)
		else $error("shutdown released early");
	a_battery_overvoltage_react: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(bat_ovp && !rd_fault) |=> switching_stop_o && fault_hist_q[0])
		else $error("battery overvoltage not handled");

endmodule

// ===== test/charger_host_model.sv
`timescale 1ns/100ps
module charger_host_model
(
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	// bus idle from time zero so the slave never sees an unknown strobe
	initial
	begin
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one classic cycle, held until ack; reads clear latched history, so callers
	// read twice to learn present conditions
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic ok);
		int n;
		ok = 1'b0;
		q = '0;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hf;
		dat_o <= d;
		// bounded wait; the caller turns a missing ack into a failure
		for (n = 0; n < 40 && !ok; n++)
		begin
			@(posedge clk_i);
			if (ack_i === 1'b1)
			begin
				q = dat_i;
				ok = 1'b1;
			end
		end
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
	endtask
endmodule

// ===== test/charger_status_fault_reporting_tb_top.sv
`timescale 1ns/100ps
`include "charger_status_regs.svh"
module charger_status_fault_reporting_tb_top import charger_status_pkg::*;;
	localparam int PULSE = 8;
	logic ref_clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i, vac_above_ovp_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [1:0] loop_set;
	logic vbus_above_uvlo_i, vbus_above_bat_i, poor_source_ok_i, source_detect_done_i, source_identified_i;
	logic charging_i, charge_done_i, topoff_running_i, safety_timer_expired_i, thermistor_fault_i, sys_over_i;
	logic accessory_supply_node_above_poor_i, accessory_supply_node_above_bst_ovp_i, blocking_switch_oc_i, battery_depleted_i, battery_switch_oc_i;
	logic input_voltage_limit_loop_i, input_current_limit_loop_i, tj_above_110_i, tj_above_150_i;
	logic tj_below_130_i, tj_below_145_i, vbat_over_i, stat_o, stat_oe_o, int_n_o, accessory_power_ok_o;
	logic switching_stop_o, sys_discharge_en_o, converter_off_o, battery_switch_off_o, boost_active_o;
	logic charge_current_reduce_o, termination_disable_o, timer_half_rate_o;
	int err_count, compares;

	// loop inputs share a vector so both can be walked in one loop
	assign input_current_limit_loop_i = loop_set[0];
	assign input_voltage_limit_loop_i = loop_set[1];

	// short pulse and blink counts keep the run brief
	charger_status_fault_reporting #(.INT_PULSE_CYCLES(PULSE), .BLINK_HALF_CYCLES(4)) dut (.*);
	charger_host_model host (.clk_i(ref_clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
		.stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));

	// 40 MHz clock
	initial
	begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// comparisons and bus helpers
	task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_pin(input string n, input logic e, input logic g);
		compares++;
		if (g !== e)
		begin
			err_count++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic end_sim();
		if (err_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic stall();
		err_count++;
		$display("Error bus ack expected 1 seen 0");
		end_sim();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] q;
		logic ok;
		host.xfer(1'b0, a, 32'h0, q, ok);
		if (ok !== 1'b1)
			stall();
		chk_val($sformatf("reg %h", a), {24'h0, e}, q & {24'hffffff, m});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic ok;
		host.xfer(1'b1, a, {24'h0, d}, q, ok);
		if (ok !== 1'b1)
			stall();
	endtask
	// lets the synchronisers and registered outputs catch up
	task automatic settle();
		repeat (6) @(posedge ref_clk_i);
	endtask
	// looks for a pulse start in a bounded window, then times its width
	task automatic wait_int(input logic e);
		int n;
		logic s;
		// a pulse launched at the caller's own edge is already low here
		#1;
		s = (int_n_o === 1'b0);
		for (n = 0; n < 30 && !s; n++)
		begin
			@(posedge ref_clk_i);
			#1;
			s = (int_n_o === 1'b0);
		end
		chk_pin("int pulse", e, s);
		n = 0;
		while (s && int_n_o === 1'b0 && n < 40)
		begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		if (s)
			chk_val("int width", PULSE, n);
		@(posedge ref_clk_i);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		int i;
		int t;
		logic p;
		rst_i = 1'b1;
		{vbus_above_uvlo_i, vbus_above_bat_i, poor_source_ok_i, source_detect_done_i, source_identified_i} = '0;
		{charging_i, charge_done_i, topoff_running_i, safety_timer_expired_i, thermistor_fault_i} = '0;
		{sys_over_i, accessory_supply_node_above_poor_i, accessory_supply_node_above_bst_ovp_i, blocking_switch_oc_i, battery_depleted_i} = '0;
		{battery_switch_oc_i, tj_above_110_i, tj_above_150_i, vbat_over_i} = '0;
		tj_below_130_i = 1'b1;
		tj_below_145_i = 1'b1;
		loop_set = 2'h0;
		vac_above_ovp_i = 4'h0;
		err_count = 0;
		compares = 0;
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		settle();
		chk_pin("int_n idle", 1'b1, int_n_o);
		rd(`CSR_CTRL_OFS, 8'hff, 8'h03);
		// input good needs detection finished as well
		vbus_above_uvlo_i <= 1'b1;
		vbus_above_bat_i <= 1'b1;
		poor_source_ok_i <= 1'b1;
		charging_i <= 1'b1;
		settle();
		rd(`CSR_LIVE_OFS, 8'h01, 8'h00);
		source_detect_done_i <= 1'b1;
		wait_int(1'b1);
		rd(`CSR_LIVE_OFS, 8'h01, 8'h01);
		chk_pin("acc ok", 1'b1, accessory_power_ok_o);
		chk_pin("stat oe", 1'b1, stat_oe_o);
		rd(`CSR_CHANGE_OFS, 8'hff, 8'h40);
		rd(`CSR_CHANGE_OFS, 8'hff, 8'h00);
		source_identified_i <= 1'b1;
		charge_done_i <= 1'b1;
		wait_int(1'b1);
		chk_pin("stat oe", 1'b0, stat_oe_o);
		rd(`CSR_CHANGE_OFS, 8'hff, 8'h30);
		rd(`CSR_CHANGE_OFS, 8'hff, 8'h00);
		blocking_switch_oc_i <= 1'b1;
		settle();
		chk_pin("acc ok", 1'b0, accessory_power_ok_o);
		blocking_switch_oc_i <= 1'b0;
		// each regulation loop interrupts while unmasked
		for (i = 0; i < 2; i++)
		begin
			loop_set <= 2'h1 << i;
			wait_int(1'b1);
			rd(`CSR_CHANGE_OFS, 8'h03, 8'h01 << i);
			loop_set <= 2'h0;
			settle();
		end
		wr(`CSR_CTRL_OFS, 8'h1b);
		loop_set <= 2'h3;
		wait_int(1'b0);
		loop_set <= 2'h0;
		settle();
		wr(`CSR_CTRL_OFS, 8'h03);
		// thresholds below the selected one do not trip
		vac_above_ovp_i <= 4'h7;
		settle();
		chk_pin("switch stop", 1'b0, switching_stop_o);
		wr(`CSR_CTRL_OFS, 8'h00);
		wait_int(1'b1);
		chk_pin("switch stop", 1'b1, switching_stop_o);
		chk_pin("acc ok", 1'b0, accessory_power_ok_o);
		t = 0;
		p = stat_oe_o;
		for (i = 0; i < 16; i++)
		begin
			@(posedge ref_clk_i);
			#1;
			if (stat_oe_o !== p)
				t++;
			p = stat_oe_o;
		end
		chk_val("blink toggles", 4, t);
		@(posedge ref_clk_i);
		vbat_over_i <= 1'b1;
		wait_int(1'b0);
		vac_above_ovp_i <= 4'h0;
		settle();
		chk_pin("switch stop", 1'b1, switching_stop_o);
		vbat_over_i <= 1'b0;
		settle();
		chk_pin("switch stop", 1'b0, switching_stop_o);
		rd(`CSR_FAULT_OFS, 8'hff, 8'h18);
		rd(`CSR_FAULT_OFS, 8'hff, 8'h00);
		rd(`CSR_CHANGE_OFS, 8'hff, 8'h40);
		rd(`CSR_CHANGE_OFS, 8'hff, 8'h00);
		wr(`CSR_CTRL_OFS, 8'h03);
		sys_over_i <= 1'b1;
		settle();
		chk_pin("sink", 1'b1, sys_discharge_en_o);
		chk_pin("switch stop", 1'b1, switching_stop_o);
		sys_over_i <= 1'b0;
		settle();
		chk_pin("sink", 1'b0, sys_discharge_en_o);
		// thermal regulation, then shutdown with hysteresis
		tj_above_110_i <= 1'b1;
		settle();
		chk_pin("current reduce", 1'b1, charge_current_reduce_o);
		chk_pin("term disable", 1'b1, termination_disable_o);
		chk_pin("half rate", 1'b1, timer_half_rate_o);
		rd(`CSR_LIVE_OFS, 8'h80, 8'h80);
		tj_above_150_i <= 1'b1;
		tj_below_130_i <= 1'b0;
		tj_below_145_i <= 1'b0;
		wait_int(1'b1);
		chk_pin("conv off", 1'b1, converter_off_o);
		chk_pin("bat sw off", 1'b1, battery_switch_off_o);
		wr(`CSR_CTRL_OFS, 8'h07);
		rd(`CSR_CTRL_OFS, 8'h04, 8'h00);
		tj_above_150_i <= 1'b0;
		tj_below_145_i <= 1'b1;
		settle();
		chk_pin("conv off", 1'b1, converter_off_o);
		tj_below_130_i <= 1'b1;
		tj_above_110_i <= 1'b0;
		settle();
		chk_pin("conv off", 1'b0, converter_off_o);
		rd(`CSR_FAULT_OFS, 8'hff, 8'h20);
		rd(`CSR_FAULT_OFS, 8'hff, 8'h00);
		safety_timer_expired_i <= 1'b1;
		wait_int(1'b1);
		safety_timer_expired_i <= 1'b0;
		settle();
		rd(`CSR_FAULT_OFS, 8'hff, 8'h30);
		rd(`CSR_FAULT_OFS, 8'hff, 8'h00);
		// adapter removed, then boost and its exits
		vbus_above_bat_i <= 1'b0;
		vbus_above_uvlo_i <= 1'b0;
		wait_int(1'b1);
		chk_pin("acc ok", 1'b0, accessory_power_ok_o);
		rd(`CSR_CHANGE_OFS, 8'hff, 8'h40);
		rd(`CSR_CHANGE_OFS, 8'hff, 8'h00);
		wr(`CSR_CTRL_OFS, 8'h07);
		settle();
		chk_pin("boost", 1'b1, boost_active_o);
		chk_pin("acc ok", 1'b0, accessory_power_ok_o);
		accessory_supply_node_above_poor_i <= 1'b1;
		settle();
		chk_pin("acc ok", 1'b1, accessory_power_ok_o);
		accessory_supply_node_above_bst_ovp_i <= 1'b1;
		wait_int(1'b1);
		chk_pin("boost", 1'b0, boost_active_o);
		chk_pin("acc ok", 1'b0, accessory_power_ok_o);
		rd(`CSR_CTRL_OFS, 8'h04, 8'h00);
		accessory_supply_node_above_bst_ovp_i <= 1'b0;
		rd(`CSR_FAULT_OFS, 8'hff, 8'h40);
		rd(`CSR_FAULT_OFS, 8'hff, 8'h00);
		wr(`CSR_CTRL_OFS, 8'h07);
		settle();
		chk_pin("acc ok", 1'b1, accessory_power_ok_o);
		battery_switch_oc_i <= 1'b1;
		wait_int(1'b1);
		chk_pin("acc ok", 1'b0, accessory_power_ok_o);
		battery_switch_oc_i <= 1'b0;
		settle();
		chk_pin("boost", 1'b0, boost_active_o);
		wr(`CSR_CTRL_OFS, 8'h03);
		rd(`CSR_FAULT_OFS, 8'hff, 8'h40);
		rd(`CSR_FAULT_OFS, 8'hff, 8'h00);
		// unmapped read and a write to a read-only place
		rd(8'h10, 8'hff, 8'h00);
		wr(`CSR_FAULT_OFS, 8'hff);
		rd(`CSR_FAULT_OFS, 8'hff, 8'h00);
		end_sim();
	end
endmodule
